// ### hdl/asrw_pkg.sv
// Package: register map, field positions, reset values and timing counts
`default_nettype none
package asrw_pkg;
   // Register byte offsets, one aligned 32-bit word each
   localparam logic [7:0] OFS_RCV_STAT    = 8'h00;
   localparam logic [7:0] OFS_TX_BUF      = 8'h04;
   localparam logic [7:0] OFS_TX_STAT     = 8'h08;
   localparam logic [7:0] OFS_BAUD_CTL    = 8'h0C;
   localparam logic [7:0] OFS_BAUD_DIV_HI = 8'h10;
   localparam logic [7:0] OFS_BAUD_DIV_LO = 8'h14;
   localparam logic [7:0] OFS_RCV_BUF     = 8'h18;
   localparam logic [7:0] OFS_RX_IRQ      = 8'h1C;
   // receive_status_control fields
   localparam int RCS_SERIAL_PORT_ENABLE  = 7;
   localparam int RCS_RX9   = 6;
   localparam int RCS_SINGLE_RECEIVE_ENABLE  = 5;
   localparam int RCS_CONTINUOUS_RX_ENABLE  = 4;
   localparam int RCS_ADDRESS_DETECT_ENABLE = 3;
   localparam int RCS_FRAMING_ERROR  = 2;
   localparam int RCS_OVERRUN_ERROR  = 1;
   localparam int RCS_RX_NINTH_BIT  = 0;
   // transmit_status_control fields
   localparam int TXS_SYNC  = 4;
   localparam int TXS_HIGH_SPEED_BAUD  = 2;
   localparam int TXS_SHIFTER_EMPTY  = 1;
   // baud_control fields
   localparam int BDC_AUTOBAUD_OVERFLOW = 7;
   localparam int BDC_RECEIVER_IDLE  = 6;
   localparam int BDC_RXINV  = 5;
   localparam int BDC_TXINV  = 4;
   localparam int BDC_WIDE_BAUD_DIVISOR  = 3;
   localparam int BDC_WAKE   = 1;
   localparam int BDC_AUTOBAUD_ENABLE  = 0;
   // rx irq register fields
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_EN   = 1;
   localparam int IRQ_PRIO = 2;
   // Reset values
   localparam logic [7:0] RST_RCV_STAT = 8'h00;
   localparam logic [7:0] RST_TX_STAT  = 8'h02;
   localparam logic [7:0] RST_BAUD_CTL = 8'h00;
   localparam logic [7:0] RST_DIV      = 8'h00;
   // Writable masks; hardware bits excluded, unimplemented bits too except in transmit status
   localparam logic [7:0] WMASK_RCV_STAT = 8'hF8;
   localparam logic [7:0] WMASK_TX_STAT  = 8'hFD;
   localparam logic [7:0] WMASK_BAUD_CTL = 8'hBB;
   // Timing: samples per bit and sample point
   localparam int OVERSAMPLE   = 16;
   localparam int SAMPLE_POINT = 7;
   localparam int SLOW_PRESCALE = 4;
   typedef enum logic [1:0] {
      RX_IDLE, RX_START, RX_DATA, RX_STOP
   } asrw_rx_state_t;
endpackage
`default_nettype wire

// ### hdl/asrw_top.sv
// Async serial receiver with break wake-up, AHB-Lite register slave
//
// Notes on behaviour
// - x16 sampling feeds bit-rate shift register
// - rx_invert flips line before recovery
// - Frames accepted only while continuous enable
// - Character done sets flag, enabled irq
// - Status holds ninth bit and errors
// - Clearing continuous enable clears errors
// - Ninth-bit mode captures nine data bits
// - Address detect in ninth-bit mode drops ninth-bit-clear characters
// - Sleep stops baud generator and reception
// - Wake enable suspends reception, monitors line
// - Falling edge under wake enable wakes
// - Wake-up event sets done flag
// - Buffer read clears done flag
// - Rising edge after wake clears enable
// - Unimplemented bits read as zero, except in transmit status
// - Frame: start, 8/9 data, stop
// - LSB first, shared format and rate
//
// Chosen here: the AHB-Lite slave port and the address map.
`default_nettype none
module asrw_top
   import asrw_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input  wire  logic        clk,
   input  wire  logic        sys_rst,
   input  wire  logic        hsel,
   input  wire  logic [31:0] haddr,
   input  wire  logic [1:0]  htrans,
   input  wire  logic        hwrite,
   input  wire  logic [2:0]  hsize,
   input  wire  logic [31:0] hwdata,
   input  wire  logic        hready,
   output var   logic        hreadyout,
   output var   logic        hresp,
   output var   logic [31:0] hrdata,
   input  wire  logic        serial_in_line,
   input  wire  logic        sleep_mode,
   output var   logic        rx_irq,
   output var   logic        rx_irq_high,
   output var   logic        wake_event
);

   // Divisor pair is wired as two fixed bytes; refuse other widths
   if (DIV_W != 16) begin : g_div_w_check
      $error("asrw_top: DIV_W must be 16");
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and shared state

   logic [7:0]  rcs_q;
   logic [7:0]  txs_q;
   logic [7:0]  bdc_q;
   logic [7:0]  div_hi_q;
   logic [7:0]  div_lo_q;
   logic [7:0]  txbuf_q;
   logic [7:0]  rxbuf_q;
   logic        rx_ninth_bit_q;
   logic        framing_error_q;
   logic        overrun_error_q;
   logic        flag_q;
   logic        irq_en_q;
   logic        irq_prio_q;

   logic        wr_pend_q;
   logic        rd_pend_q;
   logic [7:0]  addr_q;
   logic        acc_ok;
   logic        wr_hit;
   logic        rd_now;
   logic        buf_read;

   // Bus decode of the address phase
   assign acc_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
   assign wr_hit = wr_pend_q;
   assign rd_now = rd_pend_q;
   assign buf_read = rd_now && (addr_q == OFS_RCV_BUF);

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic [7:0] msk);
      merge = (old & ~msk) | (nw & msk);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: writes take no wait, reads take one

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            hreadyout <= 1'b1;
         end else begin
            wr_pend_q <= acc_ok && hwrite;
            rd_pend_q <= acc_ok && !hwrite;
            hreadyout <= !(acc_ok && !hwrite);
            if (acc_ok) begin
               addr_q <= haddr[7:0] & 8'hFC;
            end
         end
      end
   end

   logic        rx_idle;
   logic [7:0]  bdc_rd;
   assign bdc_rd = {bdc_q[BDC_AUTOBAUD_OVERFLOW], rx_idle, bdc_q[5:3], 1'b0,
                    bdc_q[BDC_WAKE], bdc_q[BDC_AUTOBAUD_ENABLE]};

   // Read data registered at the end of the wait cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_now) begin
         case (addr_q)
            OFS_RCV_STAT:    hrdata <= {24'h000000, rcs_q[7:3], framing_error_q,
                                        overrun_error_q, rx_ninth_bit_q};
            OFS_TX_BUF:      hrdata <= {24'h000000, txbuf_q};
            OFS_TX_STAT:     hrdata <= {24'h000000, txs_q};
            OFS_BAUD_CTL:    hrdata <= {24'h000000, bdc_rd};
            OFS_BAUD_DIV_HI: hrdata <= {24'h000000, div_hi_q};
            OFS_BAUD_DIV_LO: hrdata <= {24'h000000, div_lo_q};
            OFS_RCV_BUF:     hrdata <= {24'h000000, rxbuf_q};
            OFS_RX_IRQ:      hrdata <= {29'h00000000, irq_prio_q,
                                        irq_en_q, flag_q};
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Receiver-side events
   logic        wake_fall;
   logic        wake_rise;
   logic        char_done;
   logic        char_keep;
   logic        char_load;
   logic        char_framing_error;
   logic [7:0]  char_byte;
   logic        char_ninth;

   // Control registers written by software
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rcs_q      <= RST_RCV_STAT;
         txs_q      <= RST_TX_STAT;
         div_hi_q   <= RST_DIV;
         div_lo_q   <= RST_DIV;
         txbuf_q    <= 8'h00;
         irq_en_q   <= 1'b0;
         irq_prio_q <= 1'b0;
      end else if (wr_hit) begin
         case (addr_q)
            OFS_RCV_STAT:    rcs_q <= merge(rcs_q, hwdata[7:0],
                                            WMASK_RCV_STAT);
            OFS_TX_BUF:      txbuf_q <= hwdata[7:0];
            OFS_TX_STAT:     txs_q <= merge(txs_q, hwdata[7:0],
                                            WMASK_TX_STAT);
            OFS_BAUD_DIV_HI: div_hi_q <= hwdata[7:0];
            OFS_BAUD_DIV_LO: div_lo_q <= hwdata[7:0];
            OFS_RX_IRQ: begin
               irq_en_q   <= hwdata[IRQ_EN];
               irq_prio_q <= hwdata[IRQ_PRIO];
            end
            default: begin
            end
         endcase
      end
   end

   // Baud control; hardware clear of wake enable wins the cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bdc_q <= RST_BAUD_CTL;
      end else begin
         if (wr_hit && addr_q == OFS_BAUD_CTL) begin
            bdc_q <= merge(bdc_q, hwdata[7:0], WMASK_BAUD_CTL);
         end
         if (wake_rise) begin
            bdc_q[BDC_WAKE] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line synchroniser and polarity

   logic        rx_meta_q;
   logic        rx_sync_q;
   logic        rx_prev_q;
   logic        rx_line;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= serial_in_line;
         rx_sync_q <= rx_meta_q;
      end
   end

   assign rx_line = rx_sync_q ^ bdc_q[BDC_RXINV];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_prev_q <= 1'b1;
      end else begin
         rx_prev_q <= rx_line;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Baud generator: one-cycle tick at sixteen times the bit rate

   logic [17:0] baud_cnt_q;
   logic [17:0] baud_top;
   logic        tick;
   logic        rx_run;
   logic        brg_run;
   logic        start_seen;
   logic [15:0] div_val;

   // async only with port enabled and sync clear
   assign brg_run = rcs_q[RCS_SERIAL_PORT_ENABLE] && !txs_q[TXS_SYNC] && !sleep_mode;
   assign rx_run  = brg_run && rcs_q[RCS_CONTINUOUS_RX_ENABLE] && !bdc_q[BDC_WAKE]
                    && !overrun_error_q;

   assign div_val = bdc_q[BDC_WIDE_BAUD_DIVISOR] ? {div_hi_q, div_lo_q}
                                     : {8'h00, div_lo_q};
   // Fastest setting falls back to x16 timing: no x64 sampler here
   assign baud_top = (!bdc_q[BDC_WIDE_BAUD_DIVISOR] && !txs_q[TXS_HIGH_SPEED_BAUD])
                     ? 18'(SLOW_PRESCALE * (int'(div_val) + 1) - 1)
                     : {2'b00, div_val};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         baud_cnt_q <= 18'h00000;
      end else if (!brg_run || start_seen) begin
         baud_cnt_q <= 18'h00000;
      end else if (baud_cnt_q >= baud_top) begin
         baud_cnt_q <= 18'h00000;
      end else begin
         baud_cnt_q <= baud_cnt_q + 18'h00001;
      end
   end

   assign tick = brg_run && !start_seen && (baud_cnt_q >= baud_top);

   ////////////////////////////////////////////////////////////////////////
   // Receive state machine

   asrw_rx_state_t st_q;
   logic [3:0]  smp_q;
   logic [3:0]  bit_q;
   logic [8:0]  shift_q;
   logic [3:0]  nbits;
   logic        mid;

   assign start_seen = rx_run && (st_q == RX_IDLE) && rx_prev_q
                       && !rx_line;
   assign mid   = tick && (smp_q == 4'(SAMPLE_POINT));
   assign nbits = rcs_q[RCS_RX9] ? 4'h9 : 4'h8;
   assign rx_idle = (st_q == RX_IDLE);

   // sixteen samples per bit, shifter moves once per bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q    <= RX_IDLE;
         smp_q   <= 4'h0;
         bit_q   <= 4'h0;
         shift_q <= 9'h000;
      end else if (!rx_run) begin
         st_q  <= RX_IDLE;
         smp_q <= 4'h0;
      end else begin
         if (tick) begin
            smp_q <= smp_q + 4'h1;
         end
         case (st_q)
            RX_IDLE: begin
               if (start_seen) begin
                  st_q  <= RX_START;
                  smp_q <= 4'h0;
               end
            end
            RX_START: begin
               if (mid) begin
                  // Glitch shorter than half a bit is dropped
                  st_q  <= rx_line ? RX_IDLE : RX_DATA;
                  bit_q <= 4'h0;
               end
            end
            RX_DATA: begin
               if (mid) begin
                  shift_q <= {rx_line, shift_q[8:1]};
                  bit_q   <= bit_q + 4'h1;
                  if (bit_q + 4'h1 == nbits) begin
                     st_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (mid) begin
                  st_q <= RX_IDLE;
               end
            end
            default: st_q <= RX_IDLE;
         endcase
      end
   end

   assign char_done  = rx_run && (st_q == RX_STOP) && mid;
   assign char_framing_error  = !rx_line;
   assign char_byte  = rcs_q[RCS_RX9] ? shift_q[7:0] : shift_q[8:1];
   assign char_ninth = rcs_q[RCS_RX9] ? shift_q[8] : 1'b0;
   assign char_keep  = !(rcs_q[RCS_ADDRESS_DETECT_ENABLE] && rcs_q[RCS_RX9]
                         && !char_ninth);
   // Set wins: a character landing on the draining read is kept
   assign char_load  = char_done && char_keep && (!flag_q || buf_read);

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer, error flags, done flag

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxbuf_q <= 8'h00;
         rx_ninth_bit_q  <= 1'b0;
      end else if (char_load) begin
         rxbuf_q <= char_byte;
         rx_ninth_bit_q  <= char_ninth;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         framing_error_q <= 1'b0;
         overrun_error_q <= 1'b0;
      end else if (!rcs_q[RCS_CONTINUOUS_RX_ENABLE]) begin
         framing_error_q <= 1'b0;
         overrun_error_q <= 1'b0;
      end else if (char_done && char_keep) begin
         if (flag_q && !buf_read) begin
            overrun_error_q <= 1'b1;
         end else begin
            framing_error_q <= char_framing_error;
         end
      end
   end

   // Wake-up monitor, runs even with the baud generator stopped
   logic        wake_armed_q;
   logic        wake_on;
   assign wake_on = rcs_q[RCS_SERIAL_PORT_ENABLE] && bdc_q[BDC_WAKE];
   assign wake_fall = wake_on && !wake_armed_q && rx_prev_q && !rx_line;
   assign wake_rise = wake_on && wake_armed_q && !rx_prev_q && rx_line;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_armed_q <= 1'b0;
         wake_event   <= 1'b0;
      end else begin
         wake_event <= wake_fall;
         if (!wake_on || wake_rise) begin
            wake_armed_q <= 1'b0;
         end else if (wake_fall) begin
            wake_armed_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         flag_q <= 1'b0;
      end else if (char_load || wake_fall) begin
         flag_q <= 1'b1;
      end else if (buf_read) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_irq      <= 1'b0;
         rx_irq_high <= 1'b0;
      end else begin
         rx_irq      <= flag_q && irq_en_q;
         rx_irq_high <= flag_q && irq_en_q && irq_prio_q;
      end
   end

endmodule
`default_nettype wire

// ### verification/asrw_checker.sv
// Checker: bus read timing, interrupt and wake-up relations at the ports
`default_nettype none
module asrw_checker (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        hsel,
   input wire logic        hready,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        serial_in_line,
   input wire logic        sleep_mode,
   input wire logic        rx_irq,
   input wire logic        rx_irq_high,
   input wire logic        wake_event
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   ///////////////////////////////////////////////////////////////////////
   sequence rd_taken;
      hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   read_wait_a: assert property (rd_taken |=> one_wait)
      else $error("read data phase is not two cycles");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0)
      else $error("unused read data bits are not zero");
   resp_okay_a: assert property (!hresp)
      else $error("bus response is not okay");
   reset_quiet_a: assert property ($fell(sys_rst) |->
      hreadyout && !rx_irq && !rx_irq_high && !wake_event)
      else $error("outputs not idle after reset");
   prio_follow_a: assert property (rx_irq_high |-> rx_irq)
      else $error("high priority request without receive request");
   // Only a buffer read or a register write may drop the request;
   // flag clears at the read's wait edge, request one edge later
   irq_clear_a: assert property ($fell(rx_irq) |->
      !$past(hreadyout, 2) ||
      ($past(hsel, 3) && $past(htrans[1], 3) && $past(hwrite, 3)))
      else $error("receive request dropped without bus access");
   wake_pulse_a: assert property (wake_event |=> !wake_event)
      else $error("wake pulse longer than one cycle");
   wake_cause_a: assert property (wake_event |->
      !$past(serial_in_line) && !$past(serial_in_line, 2))
      else $error("wake pulse without low line");
   // In sleep a request may only come from a low line, never a stop bit
   sleep_irq_a: assert property ($rose(rx_irq) && sleep_mode &&
      $past(sleep_mode, 4) |-> !$past(serial_in_line, 2))
      else $error("character received during sleep");
endmodule
bind asrw_top asrw_checker i_asrw_checker (.*);
`default_nettype wire

// ### verification/asrw_line_model.sv
// Partner: remote asynchronous transmitter driving the receive line
`default_nettype none
module asrw_line_model #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic clk,
   output var  logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic inv = 1'h0;
   initial line = 1'h1;
   task automatic hold(input logic v, input int n);
      @(posedge clk);
      line <= v ^ inv;
      repeat (n - 1) @(posedge clk);
   endtask
   // Polarity swap only while the receiver is disabled
   task automatic set_inv(input logic v);
      @(posedge clk);
      inv = v;
      line <= ~v;
   endtask
   task automatic send(input logic [8:0] d, input logic nine,
                       input logic stp);
      hold(1'h0, BIT_CLKS);
      for (int i = 0; i < (nine ? 9 : 8); i++) hold(d[i], BIT_CLKS);
      hold(stp, BIT_CLKS);
      hold(1'h1, 2);
   endtask
endmodule
`default_nettype wire

// ### verification/async_serial_receiver_wakeup_tb.sv
// Testbench: register access and serial reception scenarios
`default_nettype none
module async_serial_receiver_wakeup_tb import asrw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic        hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic        sleep_mode = 1'h0;
   wire  logic  hreadyout, hresp, rx_irq, rx_irq_high, wake_event, line;
   wire  logic [31:0] hrdata;
   int          miscompares = 0;
   int          checked = 0;
   int          wakes = 0;
   asrw_top i_asrw_top (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .serial_in_line(line),
      .sleep_mode(sleep_mode), .rx_irq(rx_irq),
      .rx_irq_high(rx_irq_high), .wake_event(wake_event));
   // Divisor 1 with high speed: 2 clocks a tick, 32 a bit
   asrw_line_model #(.BIT_CLKS(32)) i_asrw_line_model (.clk(clk),
      .line(line));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (wake_event === 1'h1) wakes <= wakes + 1;
   ///////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'h1) begin
         if (++n > 50) begin
            miscompares++;
            finish_test;
         end
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, d,
                      output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [31:0] x;
      bus(1'h1, a, d, x);
   endtask
   task automatic rc(input logic [7:0] a, e);
      logic [31:0] x;
      bus(1'h0, a, 8'h00, x);
      check(x, {24'h0, e});
   endtask
   // A flag that never comes ends the run at once
   task automatic irq_is(input logic e);
      int n;
      n = 0;
      while (rx_irq !== e && n < 60) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, rx_irq}, {31'h0, e});
      if (n >= 60) finish_test;
   endtask
   task automatic tx(input logic [8:0] d, input logic nine, s);
      i_asrw_line_model.send(d, nine, s);
   endtask
   task automatic ended(input string s);
      $display("test %s finished", s);
   endtask
   initial begin
      #1000000;
      miscompares++;
      finish_test;
   end
   initial begin
      logic [31:0] x;
      repeat (12) @(posedge clk);
      sys_rst <= 1'h0;
      rc(OFS_RCV_STAT, 8'h00);
      rc(OFS_TX_STAT, 8'h02);
      rc(OFS_BAUD_CTL, 8'h40);
      rc(8'h20, 8'h00);
      wr(OFS_BAUD_CTL, 8'h8D);
      rc(OFS_BAUD_CTL, 8'hC9);
      wr(OFS_BAUD_CTL, 8'h00);
      wr(OFS_BAUD_DIV_LO, 8'h01);
      wr(OFS_TX_STAT, 8'h04);
      rc(OFS_TX_STAT, 8'h06);
      wr(OFS_RX_IRQ, 8'h06);
      wr(OFS_RCV_STAT, 8'h90);
      ended("registers");
      tx(9'h04B, 1'h0, 1'h1);
      irq_is(1'h1);
      rc(OFS_RX_IRQ, 8'h07);
      check({31'h0, rx_irq_high}, 32'h1);
      rc(OFS_RCV_STAT, 8'h90);
      rc(OFS_RCV_BUF, 8'h4B);
      irq_is(1'h0);
      tx(9'h0C3, 1'h0, 1'h0);
      rc(OFS_RCV_STAT, 8'h94);
      rc(OFS_RCV_BUF, 8'hC3);
      tx(9'h0F0, 1'h0, 1'h1);
      tx(9'h00F, 1'h0, 1'h1);
      rc(OFS_RCV_STAT, 8'h92);
      rc(OFS_RCV_BUF, 8'hF0);
      wr(OFS_RCV_STAT, 8'h80);
      rc(OFS_RCV_STAT, 8'h80);
      tx(9'h055, 1'h0, 1'h1);
      irq_is(1'h0);
      ended("byte frames");
      wr(OFS_RCV_STAT, 8'hD0);
      wr(OFS_RX_IRQ, 8'h02);
      tx(9'h1C3, 1'h1, 1'h1);
      irq_is(1'h1);
      check({31'h0, rx_irq_high}, 32'h0);
      rc(OFS_RCV_STAT, 8'hD1);
      rc(OFS_RCV_BUF, 8'hC3);
      wr(OFS_RCV_STAT, 8'hD8);
      tx(9'h055, 1'h1, 1'h1);
      irq_is(1'h0);
      tx(9'h1AA, 1'h1, 1'h1);
      rc(OFS_RCV_STAT, 8'hD9);
      rc(OFS_RCV_BUF, 8'hAA);
      wr(OFS_RCV_STAT, 8'hD0);
      tx(9'h066, 1'h1, 1'h1);
      rc(OFS_RCV_BUF, 8'h66);
      ended("nine bit");
      wr(OFS_RCV_STAT, 8'h80);
      wr(OFS_BAUD_CTL, 8'h20);
      i_asrw_line_model.set_inv(1'h1);
      wr(OFS_RCV_STAT, 8'h90);
      tx(9'h03C, 1'h0, 1'h1);
      rc(OFS_RCV_BUF, 8'h3C);
      wr(OFS_RCV_STAT, 8'h80);
      wr(OFS_BAUD_CTL, 8'h00);
      i_asrw_line_model.set_inv(1'h0);
      wr(OFS_RCV_STAT, 8'h90);
      sleep_mode <= 1'h1;
      tx(9'h0A5, 1'h0, 1'h1);
      irq_is(1'h0);
      ended("polarity and sleep");
      wr(OFS_BAUD_CTL, 8'h02);
      rc(OFS_BAUD_CTL, 8'h42);
      i_asrw_line_model.hold(1'h0, 100);
      irq_is(1'h1);
      check(wakes, 32'h1);
      rc(OFS_BAUD_CTL, 8'h42);
      i_asrw_line_model.hold(1'h0, 300);
      i_asrw_line_model.hold(1'h1, 4);
      rc(OFS_BAUD_CTL, 8'h40);
      rc(OFS_RCV_STAT, 8'h90);
      bus(1'h0, OFS_RCV_BUF, 8'h00, x);
      irq_is(1'h0);
      sleep_mode <= 1'h0;
      tx(9'h05A, 1'h0, 1'h1);
      rc(OFS_RCV_BUF, 8'h5A);
      check(wakes, 32'h1);
      ended("wake on break");
      finish_test();
   end
endmodule
`default_nettype wire
